// [src/pacr_pkg.sv]
// package: register map, field layout and constants of the agent config bank
package pacr_pkg;
	// ------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [9:0] PACR_IDX_AGENT_CONFIG = 10'h0E0;
	localparam logic [9:0] PACR_IDX_AGENT1_TEMPERATURE_BASE = 10'h0E1;
	localparam logic [9:0] PACR_IDX_AGENT2_TEMPERATURE_BASE = 10'h0E2;
	localparam logic [9:0] PACR_IDX_DOMAIN       = 10'h0E5;
	localparam logic [9:0] PACR_IDX_WARN_FLAG    = 10'h0E8;
	localparam int         PACR_ADDR_W           = 12;
	localparam int         PACR_IDX_LSB          = 2;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PACR_RST_AGENT_CONFIG = 8'h00;
	localparam logic [6:0] PACR_RST_TEMPERATURE_BASE        = 7'h48;
	localparam logic [7:0] PACR_RST_DOMAIN       = 8'h00;
	localparam logic       PACR_RST_MODE         = 1'b0;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PACR_CFG_EN_LSB     = 4;  // agent enables 7:4
	localparam int PACR_CFG_SEL_LSB    = 0;  // domain1 selects 3:0
	localparam int PACR_DOM_HAS_LSB    = 4;  // has-domain1 bits 7:4
	localparam int PACR_DOM_RETHI_BIT  = 1;  // return-highest bit
	localparam int PACR_WARN_MODE_BIT  = 3;  // relative-temperature view
	localparam int PACR_WARN_STAT_LSB  = 4;  // alert / absent bits 7:4
	// ------------------------------------------------------------
	// link client addresses
	// ------------------------------------------------------------
	localparam logic [7:0] PACR_CLIENT_ADDR_BASE = 8'h30;
	// ------------------------------------------------------------
	// axi responses
	// ------------------------------------------------------------
	localparam logic [1:0] PACR_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PACR_RESP_SLVERR = 2'h2;
endpackage

// [src/pacr_regs.sv]
// agent configuration register bank with AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pacr_regs
	import pacr_pkg::*;
(
	input  wire logic                   CLK_SYS,          // 40 MHz system clock
	input  wire logic                   ARST_N,           // async reset, active low
	input  wire logic [PACR_ADDR_W-1:0] S_AXI_AWADDR,     // write address
	input  wire logic                   S_AXI_AWVALID,    // write address valid
	output logic                        S_AXI_AWREADY,    // write address ready
	input  wire logic [31:0]            S_AXI_WDATA,      // write data
	input  wire logic [3:0]             S_AXI_WSTRB,      // write byte strobes
	input  wire logic                   S_AXI_WVALID,     // write data valid
	output logic                        S_AXI_WREADY,     // write data ready
	output logic [1:0]                  S_AXI_BRESP,      // write response
	output logic                        S_AXI_BVALID,     // write response valid
	input  wire logic                   S_AXI_BREADY,     // write response ready
	input  wire logic [PACR_ADDR_W-1:0] S_AXI_ARADDR,     // read address
	input  wire logic                   S_AXI_ARVALID,    // read address valid
	output logic                        S_AXI_ARREADY,    // read address ready
	output logic [31:0]                 S_AXI_RDATA,      // read data
	output logic [1:0]                  S_AXI_RRESP,      // read response
	output logic                        S_AXI_RVALID,     // read data valid
	input  wire logic                   S_AXI_RREADY,     // read data ready
	input  wire logic [7:0]             AGENT1_REL_LO,    // agent 1 relative temp low byte
	input  wire logic [7:0]             AGENT1_REL_HI,    // agent 1 relative temp high byte
	input  wire logic [7:0]             AGENT2_REL_LO,    // agent 2 relative temp low byte
	input  wire logic [3:0]             AGENT_ALERT,      // bad frame check, agents 4..1
	input  wire logic [3:0]             AGENT_ABSENT,     // agent not detected, agents 4..1
	input  wire logic [1:0]             AGENT_SEL,        // agent being addressed, 0 = agent 1
	output logic [3:0]                  AGENT_ENABLE,     // agent enables 4..1
	output logic [3:0]                  AGENT_DOMAIN1,    // effective domain 1 use 4..1
	output logic                        RETURN_HIGHEST,   // return highest of both domains
	output logic [6:0]                  AGENT1_TEMP_BASE, // agent 1 temperature base
	output logic [6:0]                  AGENT2_TEMP_BASE, // agent 2 temperature base
	output logic                        REL_TEMP_MODE,    // relative-temperature view on
	output logic [7:0]                  CLIENT_ADDR       // link client address of AGENT_SEL
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0]             peci_agent_config;
	logic [6:0]             agent1_temp_base;
	logic [6:0]             agent2_temp_base;
	logic [7:0]             domain_reg;
	logic                   mode;
	logic [PACR_ADDR_W-1:0] aw_addr;
	logic [7:0]             w_byte;
	logic                   w_lane0;
	logic                   aw_held;
	logic                   w_held;
	logic                   do_write;
	logic                   do_read;
	logic [9:0]             w_idx;
	logic [9:0]             r_idx;
	logic                   w_hit;
	logic                   r_hit;
	logic [7:0]             next_rdata;

	assign w_idx    = aw_addr[PACR_IDX_LSB +: 10];
	assign r_idx    = S_AXI_ARADDR[PACR_IDX_LSB +: 10];
	assign do_write = aw_held && w_held && !S_AXI_BVALID;
	assign do_read  = S_AXI_ARVALID && S_AXI_ARREADY;

	assign w_hit = (w_idx == PACR_IDX_AGENT_CONFIG) || (w_idx == PACR_IDX_AGENT1_TEMPERATURE_BASE)
		|| (w_idx == PACR_IDX_AGENT2_TEMPERATURE_BASE) || (w_idx == PACR_IDX_DOMAIN)
		|| (w_idx == PACR_IDX_WARN_FLAG);
	assign r_hit = (r_idx == PACR_IDX_AGENT_CONFIG) || (r_idx == PACR_IDX_AGENT1_TEMPERATURE_BASE)
		|| (r_idx == PACR_IDX_AGENT2_TEMPERATURE_BASE) || (r_idx == PACR_IDX_DOMAIN)
		|| (r_idx == PACR_IDX_WARN_FLAG);

	// ------------------------------------------------------------
	// write channel capture
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			aw_held       <= 1'b0;
			aw_addr       <= '0;
			S_AXI_AWREADY <= 1'b0;
		end
		else if (S_AXI_AWVALID && S_AXI_AWREADY)
		begin
			aw_held       <= 1'b1;
			aw_addr       <= S_AXI_AWADDR;
			S_AXI_AWREADY <= 1'b0;
		end
		else if (do_write)
			aw_held <= 1'b0;
		else if (!aw_held && !S_AXI_BVALID)
			S_AXI_AWREADY <= 1'b1;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			w_held       <= 1'b0;
			w_byte       <= '0;
			w_lane0      <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end
		else if (S_AXI_WVALID && S_AXI_WREADY)
		begin
			w_held       <= 1'b1;
			w_byte       <= S_AXI_WDATA[7:0];
			w_lane0      <= S_AXI_WSTRB[0];
			S_AXI_WREADY <= 1'b0;
		end
		else if (do_write)
			w_held <= 1'b0;
		else if (!w_held && !S_AXI_BVALID)
			S_AXI_WREADY <= 1'b1;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= PACR_RESP_OKAY;
		end
		else if (do_write)
		begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= w_hit ? PACR_RESP_OKAY : PACR_RESP_SLVERR;
		end
		else if (S_AXI_BREADY)
			S_AXI_BVALID <= 1'b0;
	end

	// ------------------------------------------------------------
	// register updates
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			peci_agent_config <= PACR_RST_AGENT_CONFIG;
			agent1_temp_base  <= PACR_RST_TEMPERATURE_BASE;
			agent2_temp_base  <= PACR_RST_TEMPERATURE_BASE;
			domain_reg        <= PACR_RST_DOMAIN;
			mode              <= PACR_RST_MODE;
		end
		else if (do_write && w_lane0)
		begin
			case (w_idx)
				PACR_IDX_AGENT_CONFIG: peci_agent_config <= w_byte;
				PACR_IDX_AGENT1_TEMPERATURE_BASE: agent1_temp_base  <= w_byte[6:0];
				PACR_IDX_AGENT2_TEMPERATURE_BASE: agent2_temp_base  <= w_byte[6:0];
				PACR_IDX_DOMAIN:       domain_reg        <= w_byte;
				PACR_IDX_WARN_FLAG:    mode              <= w_byte[PACR_WARN_MODE_BIT];
				default:               mode              <= mode;
			endcase
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_comb
	begin
		next_rdata = 8'h00;
		case (r_idx)
			PACR_IDX_AGENT_CONFIG:
				next_rdata = mode ? AGENT1_REL_LO : peci_agent_config;
			PACR_IDX_AGENT1_TEMPERATURE_BASE:
				next_rdata = mode ? AGENT1_REL_HI : {1'b0, agent1_temp_base};
			PACR_IDX_AGENT2_TEMPERATURE_BASE:
				next_rdata = mode ? AGENT2_REL_LO : {1'b0, agent2_temp_base};
			PACR_IDX_DOMAIN:
				next_rdata = {domain_reg[7:PACR_DOM_HAS_LSB], 2'b00,
					domain_reg[PACR_DOM_RETHI_BIT], 1'b0};
			PACR_IDX_WARN_FLAG:
				next_rdata = {(mode ? AGENT_ABSENT : AGENT_ALERT), mode, 3'b000};
			default:
				next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= '0;
			S_AXI_RRESP   <= PACR_RESP_OKAY;
		end
		else if (do_read)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RDATA   <= {24'h000000, next_rdata};
			S_AXI_RRESP   <= r_hit ? PACR_RESP_OKAY : PACR_RESP_SLVERR;
		end
		else if (S_AXI_RVALID)
		begin
			if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
		else
			S_AXI_ARREADY <= 1'b1;
	end

	// ------------------------------------------------------------
	// block outputs
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			AGENT_ENABLE     <= '0;
			AGENT_DOMAIN1    <= '0;
			RETURN_HIGHEST   <= 1'b0;
			AGENT1_TEMP_BASE <= PACR_RST_TEMPERATURE_BASE;
			AGENT2_TEMP_BASE <= PACR_RST_TEMPERATURE_BASE;
			REL_TEMP_MODE    <= PACR_RST_MODE;
			CLIENT_ADDR      <= PACR_CLIENT_ADDR_BASE;
		end
		else
		begin
			AGENT_ENABLE   <= peci_agent_config[PACR_CFG_EN_LSB +: 4];
			// select only counts where the agent has a domain 1
			AGENT_DOMAIN1  <= peci_agent_config[PACR_CFG_SEL_LSB +: 4]
				& domain_reg[PACR_DOM_HAS_LSB +: 4];
			RETURN_HIGHEST   <= domain_reg[PACR_DOM_RETHI_BIT];
			AGENT1_TEMP_BASE <= agent1_temp_base;
			AGENT2_TEMP_BASE <= agent2_temp_base;
			REL_TEMP_MODE    <= mode;
			CLIENT_ADDR      <= PACR_CLIENT_ADDR_BASE + {6'b000000, AGENT_SEL};
		end
	end
endmodule
`default_nettype wire

// [sim/pacr_agents.sv]
// model of the link agents: relative temperatures and per-agent status
`timescale 1ns/1ps
`default_nettype none
module pacr_agents
(
	input  wire logic [7:0] seed,    // temperature pattern
	input  wire logic [3:0] present, // agents that answer
	input  wire logic [3:0] bad_fcs, // agents with bad frame check
	output logic      [7:0] rel1_lo, // agent 1 low byte
	output logic      [7:0] rel1_hi, // agent 1 high byte
	output logic      [7:0] rel2_lo, // agent 2 low byte
	output logic      [3:0] alert,   // frame check alerts
	output logic      [3:0] absent   // agents not detected
);
	assign rel1_lo = seed;
	assign rel1_hi = ~seed;
	assign rel2_lo = seed + 8'h11;
	// an absent agent cannot report a bad frame
	assign alert   = bad_fcs & present;
	assign absent  = ~present;
endmodule
`default_nettype wire

// [sim/pacr_regs_properties.sv]
// checker: port-level properties of the agent config bank
`timescale 1ns/1ps
`default_nettype none
module pacr_regs_properties
	import pacr_pkg::*;
(
	input wire logic        CLK_SYS,          // clock
	input wire logic        ARST_N,           // reset
	input wire logic [11:0] S_AXI_AWADDR,     // aw
	input wire logic        S_AXI_AWVALID,    // aw
	input wire logic        S_AXI_AWREADY,    // aw
	input wire logic [31:0] S_AXI_WDATA,      // w
	input wire logic [3:0]  S_AXI_WSTRB,      // w
	input wire logic        S_AXI_WVALID,     // w
	input wire logic        S_AXI_WREADY,     // w
	input wire logic [11:0] S_AXI_ARADDR,     // ar
	input wire logic        S_AXI_ARVALID,    // ar
	input wire logic        S_AXI_ARREADY,    // ar
	input wire logic [31:0] S_AXI_RDATA,      // r
	input wire logic [7:0]  AGENT1_REL_LO,    // temp
	input wire logic [3:0]  AGENT_ALERT,      // status
	input wire logic [3:0]  AGENT_ABSENT,     // status
	input wire logic [1:0]  AGENT_SEL,        // agent
	input wire logic [3:0]  AGENT_ENABLE,     // out
	input wire logic [3:0]  AGENT_DOMAIN1,    // out
	input wire logic [6:0]  AGENT1_TEMP_BASE, // out
	input wire logic [6:0]  AGENT2_TEMP_BASE, // out
	input wire logic        REL_TEMP_MODE,    // out
	input wire logic [7:0]  CLIENT_ADDR       // out
);
	logic [7:0] cfg_s, dom_s;
	logic [6:0] b1_s, b2_s;
	logic [2:0] quiet;
	wire        wtake = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		&& S_AXI_WSTRB[0];
	wire  [9:0] widx = S_AXI_AWADDR[11:2];
	wire        settled = quiet >= 3'h4;
	// shadow copies of the config, domain and both temperature base fields
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			cfg_s <= PACR_RST_AGENT_CONFIG;
			dom_s <= PACR_RST_DOMAIN;
			b1_s  <= PACR_RST_TEMPERATURE_BASE;
			b2_s  <= PACR_RST_TEMPERATURE_BASE;
		end
		else if (wtake)
		begin
			if (widx == PACR_IDX_AGENT_CONFIG) cfg_s <= S_AXI_WDATA[7:0];
			if (widx == PACR_IDX_DOMAIN) dom_s <= S_AXI_WDATA[7:0];
			if (widx == PACR_IDX_AGENT1_TEMPERATURE_BASE) b1_s <= S_AXI_WDATA[6:0];
			if (widx == PACR_IDX_AGENT2_TEMPERATURE_BASE) b2_s <= S_AXI_WDATA[6:0];
		end
	end
	// cycles since the last accepted write, saturating
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N) quiet <= 3'h0;
		else if (wtake) quiet <= 3'h0;
		else if (quiet != 3'h7) quiet <= quiet + 3'h1;
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	sequence rd_of(logic [9:0] idx);
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[11:2] == idx;
	endsequence
	enable_map_a: assert property (settled |-> AGENT_ENABLE == cfg_s[7:4])
		else $error("agent enables differ from config");
	domain_gate_a: assert property (settled |-> AGENT_DOMAIN1 == (cfg_s[3:0] & dom_s[7:4]))
		else $error("domain 1 use not gated by presence");
	base_hold_a: assert property (settled |-> AGENT1_TEMP_BASE == b1_s && AGENT2_TEMP_BASE == b2_s)
		else $error("temperature base differs from written value");
	client_addr_a: assert property ($past(ARST_N) |-> CLIENT_ADDR == 8'h30 + {6'h00, $past(AGENT_SEL)})
		else $error("client address wrong for agent");
	rel_view_a: assert property (rd_of(PACR_IDX_AGENT_CONFIG) ##0 REL_TEMP_MODE
		|=> S_AXI_RDATA[7:0] == $past(AGENT1_REL_LO)) else $error("relative view not shown");
	status_view_a: assert property (rd_of(PACR_IDX_WARN_FLAG) |=> S_AXI_RDATA[7:4] ==
		($past(REL_TEMP_MODE) ? $past(AGENT_ABSENT) : $past(AGENT_ALERT))) else $error("bad status");
	reserved_zero_a: assert property ((rd_of(PACR_IDX_AGENT1_TEMPERATURE_BASE) or rd_of(PACR_IDX_AGENT2_TEMPERATURE_BASE))
		##0 !REL_TEMP_MODE |=> S_AXI_RDATA[31:7] == 25'h0) else $error("reserved bit not zero");
	reset_vals_a: assert property ($rose(ARST_N) |-> AGENT_ENABLE == 4'h0 && AGENT_DOMAIN1 == 4'h0
		&& AGENT1_TEMP_BASE == 7'h48 && AGENT2_TEMP_BASE == 7'h48 && !REL_TEMP_MODE)
		else $error("reset values wrong");
endmodule
bind pacr_regs pacr_regs_properties pacr_regs_properties_i (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
	.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .AGENT1_REL_LO(AGENT1_REL_LO),
	.AGENT_ALERT(AGENT_ALERT), .AGENT_ABSENT(AGENT_ABSENT), .AGENT_SEL(AGENT_SEL),
	.AGENT_ENABLE(AGENT_ENABLE), .AGENT_DOMAIN1(AGENT_DOMAIN1), .CLIENT_ADDR(CLIENT_ADDR),
	.AGENT1_TEMP_BASE(AGENT1_TEMP_BASE), .AGENT2_TEMP_BASE(AGENT2_TEMP_BASE),
	.REL_TEMP_MODE(REL_TEMP_MODE));
`default_nettype wire

// [sim/pacr_regs_tb_top.sv]
// testbench: agent config bank driven over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module pacr_regs_tb_top
	import pacr_pkg::*;
;
	logic        clk, arst_n, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv, mode, rh;
	logic [31:0] wd, rdd;
	logic [11:0] awa, ara;
	logic [7:0]  seed, lo, hi, lo2, ca;
	logic [6:0]  b1, b2;
	logic [3:0]  pres, bad, alert, absent, en, d1, ws;
	logic [1:0]  sel, br, rr;
	int          n_mismatch = 0, n_compared = 0;
	pacr_regs pacr_regs_i (.CLK_SYS(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
		.AGENT1_REL_LO(lo), .AGENT1_REL_HI(hi), .AGENT2_REL_LO(lo2), .AGENT_ALERT(alert),
		.AGENT_ABSENT(absent), .AGENT_SEL(sel), .AGENT_ENABLE(en), .AGENT_DOMAIN1(d1),
		.RETURN_HIGHEST(rh), .AGENT1_TEMP_BASE(b1), .AGENT2_TEMP_BASE(b2),
		.REL_TEMP_MODE(mode), .CLIENT_ADDR(ca));
	pacr_agents pacr_agents_i (.seed(seed), .present(pres), .bad_fcs(bad), .rel1_lo(lo),
		.rel1_hi(hi), .rel2_lo(lo2), .alert(alert), .absent(absent));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
		awa <= {i, 2'h0};
		wd  <= {24'h000000, d};
		{awv, wv, bre} <= 3'h7;
		do
		begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end
		while (!bv);
		bre <= 1'b0;
		chk({30'h0, br}, {30'h0, er});
		@(posedge clk);
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] e, input logic [1:0] er);
		ara <= {i, 2'h0};
		{arv, rre} <= 2'h3;
		do
		begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end
		while (!rv);
		rre <= 1'b0;
		chk(rdd, {24'h000000, e});
		chk({30'h0, rr}, {30'h0, er});
		@(posedge clk);
	endtask
	task automatic t_reset();
		rd(PACR_IDX_AGENT_CONFIG, 8'h00, PACR_RESP_OKAY);
		rd(PACR_IDX_AGENT1_TEMPERATURE_BASE, 8'h48, PACR_RESP_OKAY);
		rd(PACR_IDX_AGENT2_TEMPERATURE_BASE, 8'h48, PACR_RESP_OKAY);
		chk({24'h0, en, d1}, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_agents();
		wr(PACR_IDX_DOMAIN, 8'hFF, PACR_RESP_OKAY);
		rd(PACR_IDX_DOMAIN, 8'hF2, PACR_RESP_OKAY);
		for (int k = 0; k < 4; k++)
		begin
			wr(PACR_IDX_AGENT_CONFIG, 8'h11 << k, PACR_RESP_OKAY);
			chk({28'h0, en}, 32'h1 << k);
			chk({28'h0, d1}, 32'h1 << k);
		end
		wr(PACR_IDX_DOMAIN, 8'h52, PACR_RESP_OKAY);
		chk({28'h0, d1}, 32'h0);
		wr(PACR_IDX_AGENT_CONFIG, 8'h0F, PACR_RESP_OKAY);
		chk({27'h0, rh, d1}, 32'h15);
		$display("agent test done");
	endtask
	task automatic t_base();
		wr(PACR_IDX_AGENT1_TEMPERATURE_BASE, 8'hAA, PACR_RESP_OKAY);
		rd(PACR_IDX_AGENT1_TEMPERATURE_BASE, 8'h2A, PACR_RESP_OKAY);
		// byte lane 0 strobe low: the write must leave the base alone
		ws <= 4'hE;
		wr(PACR_IDX_AGENT1_TEMPERATURE_BASE, 8'h33, PACR_RESP_OKAY);
		ws <= 4'hF;
		rd(PACR_IDX_AGENT1_TEMPERATURE_BASE, 8'h2A, PACR_RESP_OKAY);
		wr(PACR_IDX_AGENT2_TEMPERATURE_BASE, 8'h15, PACR_RESP_OKAY);
		chk({18'h0, b1, b2}, 32'h1515);
		wr(10'h0F0, 8'h55, PACR_RESP_SLVERR);
		rd(10'h0F0, 8'h00, PACR_RESP_SLVERR);
		$display("base test done");
	endtask
	task automatic t_mode();
		seed <= 8'h5C;
		pres <= 4'hB;
		bad  <= 4'h6;
		wr(PACR_IDX_WARN_FLAG, 8'h08, PACR_RESP_OKAY);
		chk({31'h0, mode}, 32'h1);
		rd(PACR_IDX_AGENT_CONFIG, 8'h5C, PACR_RESP_OKAY);
		rd(PACR_IDX_AGENT1_TEMPERATURE_BASE, 8'hA3, PACR_RESP_OKAY);
		rd(PACR_IDX_AGENT2_TEMPERATURE_BASE, 8'h6D, PACR_RESP_OKAY);
		rd(PACR_IDX_WARN_FLAG, 8'h48, PACR_RESP_OKAY);
		wr(PACR_IDX_WARN_FLAG, 8'h00, PACR_RESP_OKAY);
		rd(PACR_IDX_WARN_FLAG, 8'h20, PACR_RESP_OKAY);
		$display("mode test done");
	endtask
	task automatic t_client();
		for (int s = 0; s < 4; s++)
		begin
			sel <= s[1:0];
			repeat (2) @(posedge clk);
			chk({24'h0, ca}, 32'h30 + s);
		end
		$display("client test done");
	endtask
	// reset again after every register but the mode bit has left its reset value
	task automatic t_rearm();
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		{awv, wv, bre, arv, rre, arst_n} = 6'h00;
		{awa, ara, wd, seed, pres, bad, sel} = 74'h0;
		ws = 4'hF;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_agents();
		t_base();
		t_mode();
		t_client();
		t_rearm();
		conclude();
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
